// ==== cit_regs.svh ====
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH

// register byte addresses on the host i/o space
`define CIT_EVT_ENABLES_ADDR 16'h01E3
`define CIT_EVT_FLAGS_ADDR   16'h01E4
`define CIT_CTRL_ADDR        16'h01E5
`define CIT_BASE_HIGH_ADDR   16'h01E6
`define CIT_BASE_LOW_ADDR    16'h01E7

// reset values
`define CIT_CTRL_RST         8'h00
`define CIT_BASE_HIGH_RST    8'h01
`define CIT_BASE_LOW_RST     8'hDC
`define CIT_EVT_RST          3'h0

// timer_control fields
`define CIT_CTRL_GATE2_BIT   7
`define CIT_CTRL_GATE1_BIT   6
`define CIT_CTRL_GATE0_BIT   5
`define CIT_CTRL_CHAIN_BIT   4
`define CIT_CTRL_SEL1_BIT    3
`define CIT_CTRL_SEL0_BIT    2

// counter block layout and control word fields
`define CIT_CW_PORT          2'h3
`define CIT_SC_READBACK      2'h3
`define CIT_RW_LATCH         2'h0
`define CIT_RW_LSB           2'h1
`define CIT_RW_MSB           2'h2
`define CIT_RW_BOTH          2'h3
`define CIT_RB_NCOUNT_BIT    5
`define CIT_RB_NSTATUS_BIT   4

// internal clock: pci clock edges per internal tick
`define CIT_INT_DIV          8

`endif

// ==== cit_pkg.sv ====
package cit_pkg;

  typedef enum logic [2:0] {
    mode_interrupt,
    mode_oneshot,
    mode_rate,
    mode_square,
    mode_sw_strobe,
    mode_hw_strobe
  } cnt_mode_e;

  typedef struct packed {
    logic       wr_ctrl;
    logic       wr_cnt;
    logic       rd;
    logic       rb_count;
    logic       rb_status;
    logic [7:0] data;
  } cnt_req_s;

  typedef struct packed {
    cnt_mode_e   mode;
    logic [2:0]  mode_raw;
    logic [1:0]  rw;
    logic        bcd;
    logic [15:0] cr;
    logic [15:0] ce;
    logic [15:0] ol;
    logic        latched;
    logic        st_latched;
    logic [7:0]  st;
    logic        wr_hi;
    logic        rd_hi;
    logic        null_cnt;
    logic        load_pend;
    logic        trig;
    logic        gate_q;
    logic        armed;
    logic        out;
  } cnt_s;

  typedef struct packed {
    logic [7:0]      ctrl;
    logic [7:0]      base_hi;
    logic [7:0]      base_lo;
    logic [2:0]      enables;
    logic [2:0]      flags;
    logic [2:0]      out_q;
    logic [7:0]      rdata;
    logic            rdata_en;
    cnt_s [2:0]      cnt;
  } top_s;

  typedef struct packed {
    logic [2:0] sh;
    logic       rise;
  } sync_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } div_s;

endpackage : cit_pkg

// ==== edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // level in, rising-edge pulse out
  input  wire logic din,
  output logic      rise
);

  cit_pkg::sync_s state_reg;
  cit_pkg::sync_s state_next;

  // sh[0] feeds only sh[1]; edge is judged on the settled stages
  always_comb begin
    state_next      = state_reg;
    state_next.sh   = {state_reg.sh[1:0], din};
    state_next.rise = state_reg.sh[1] & ~state_reg.sh[2];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rise = state_reg.rise;

endmodule : edge_sync

`default_nettype wire

// ==== tick_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cit_regs.svh"

module tick_divider (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // input edge pulses, one tick out per divide count
  input  wire logic en,
  output logic      tick
);

  cit_pkg::div_s state_reg;
  cit_pkg::div_s state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (en) begin
      state_next.cnt = state_reg.cnt + 3'h1;
      state_next.tick = (state_reg.cnt == 3'(`CIT_INT_DIV - 1));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule : tick_divider

`default_nettype wire

// ==== cascadable_interval_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cit_regs.svh"

module cascadable_interval_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // host byte i/o
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_en,
  // clock pins
  input  wire logic        pci_clk_in,
  input  wire logic        ext_clock_in_0,
  input  wire logic        ext_clock_in_1,
  // outputs
  output logic      [2:0]  counter_out,
  output logic             irq
);

  cit_pkg::top_s state_reg;
  cit_pkg::top_s state_next;

  logic                     pci_rise;
  logic                     ext0_rise;
  logic                     ext1_rise;
  logic                     int_tick;
  logic [15:0]              base;
  logic                     blk_hit;
  logic [2:0]               tick;
  logic [2:0]               gate;
  logic [2:0]               outs;
  logic [2:0]               flag_clr;
  cit_pkg::cnt_req_s [2:0]  req;

  // external clocks cross in through a synchroniser each
  edge_sync u_sync_pci (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (pci_clk_in),
    .rise    (pci_rise)
  );

  edge_sync u_sync_ext0 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (ext_clock_in_0),
    .rise    (ext0_rise)
  );

  edge_sync u_sync_ext1 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (ext_clock_in_1),
    .rise    (ext1_rise)
  );

  // pci clock edges divided down to the internal counter clock
  tick_divider u_int_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .en      (pci_rise),
    .tick    (int_tick)
  );

  // byte presented on a counter read, no side effects here
  function automatic logic [7:0] rd_byte(input cit_pkg::cnt_s c);
    logic [15:0] src;
    src = c.latched ? c.ol : c.ce;
    if (c.st_latched) begin
      rd_byte = c.st;
    end else if (c.rw == `CIT_RW_MSB || (c.rw == `CIT_RW_BOTH && c.rd_hi)) begin
      rd_byte = src[15:8];
    end else begin
      rd_byte = src[7:0];
    end
  endfunction : rd_byte

  // one counter for one clock: bus commands first, then counting on a tick
  function automatic cit_pkg::cnt_s cnt_step(input cit_pkg::cnt_s c, input logic tk, input logic gt,
                                             input cit_pkg::cnt_req_s q);
    cit_pkg::cnt_s s;
    logic          trg;
    logic          done;
    s    = c;
    trg  = c.trig | (gt & ~c.gate_q);
    done = 1'b0;
    s.gate_q = gt;
    if (gt && !c.gate_q) begin
      s.trig = 1'b1;
    end
    if (q.wr_ctrl) begin
      if (q.data[5:4] == `CIT_RW_LATCH) begin
        if (!c.latched) begin
          s.ol      = c.ce;
          s.latched = 1'b1;
        end
      end else begin
        s.rw       = q.data[5:4];
        s.mode_raw = q.data[3:1];
        s.mode     = q.data[2] ? cit_pkg::cnt_mode_e'({1'b0, q.data[2:1]}) : cit_pkg::cnt_mode_e'(q.data[3:1]);
        s.bcd      = q.data[0]; // stored only, counting stays binary
        s.out      = (s.mode != cit_pkg::mode_interrupt);
        s.null_cnt = 1'b1;
        s.load_pend = 1'b0;
        s.armed    = 1'b0;
        s.wr_hi    = 1'b0;
        s.rd_hi    = 1'b0;
        s.latched  = 1'b0;
        s.st_latched = 1'b0;
        s.trig     = 1'b0;
      end
    end
    if (q.wr_cnt) begin
      case (c.rw)
        `CIT_RW_LSB: begin
          s.cr = {8'h00, q.data};
          done = 1'b1;
        end
        `CIT_RW_MSB: begin
          s.cr = {q.data, 8'h00};
          done = 1'b1;
        end
        default: begin
          if (!c.wr_hi) begin
            s.cr[7:0] = q.data;
            s.wr_hi   = 1'b1;
            if (c.mode == cit_pkg::mode_interrupt) begin
              s.armed = 1'b0;
            end
          end else begin
            s.cr[15:8] = q.data;
            s.wr_hi    = 1'b0;
            done       = 1'b1;
          end
        end
      endcase
      if (done) begin
        s.null_cnt  = 1'b1;
        s.load_pend = 1'b1;
        if (c.mode == cit_pkg::mode_interrupt) begin
          s.out = 1'b0;
        end
      end
    end
    if (q.rb_count && !c.latched) begin
      s.ol      = c.ce;
      s.latched = 1'b1;
    end
    if (q.rb_status && !c.st_latched) begin
      s.st         = {c.out, c.null_cnt, c.rw, c.mode_raw, c.bcd};
      s.st_latched = 1'b1;
    end
    if (q.rd) begin
      if (c.st_latched) begin
        s.st_latched = 1'b0;
      end else if (c.rw == `CIT_RW_BOTH) begin
        s.rd_hi = ~c.rd_hi;
        if (c.rd_hi) begin
          s.latched = 1'b0;
        end
      end else begin
        s.latched = 1'b0;
      end
    end
    // a control word or count write takes this clock; counting resumes on the next tick
    if (tk && !q.wr_ctrl && !q.wr_cnt) begin
      s.trig = 1'b0;
      case (c.mode)
        cit_pkg::mode_interrupt: begin
          if (c.load_pend && !c.wr_hi) begin
            s.ce = c.cr;
            s.load_pend = 1'b0;
            s.null_cnt = 1'b0;
            s.armed = 1'b1;
          end else if (gt && c.armed) begin
            s.ce = c.ce - 16'h0001;
            if (c.ce == 16'h0001) begin
              s.out = 1'b1;
            end
          end
        end
        cit_pkg::mode_oneshot: begin
          if (trg && c.null_cnt == c.load_pend) begin
            s.ce = c.cr;
            s.load_pend = 1'b0;
            s.null_cnt = 1'b0;
            s.armed = 1'b1;
            s.out = 1'b0;
          end else if (c.armed) begin
            s.ce = c.ce - 16'h0001;
            if (c.ce == 16'h0001) begin
              s.out = 1'b1;
              s.armed = 1'b0;
            end
          end
        end
        cit_pkg::mode_rate, cit_pkg::mode_square: begin
          if (trg || (c.load_pend && !c.armed)) begin
            s.ce = (c.mode == cit_pkg::mode_square) ? (c.cr & 16'hFFFE) : c.cr;
            s.load_pend = 1'b0;
            s.null_cnt = 1'b0;
            s.armed = 1'b1;
            s.out = 1'b1;
          end else if (!gt) begin
            s.out = 1'b1;
          end else if (c.armed && c.mode == cit_pkg::mode_rate) begin
            s.ce = c.ce - 16'h0001;
            s.out = (c.ce != 16'h0002);
            if (c.ce == 16'h0001) begin
              s.ce = c.cr;
              s.load_pend = 1'b0;
              s.null_cnt = 1'b0;
            end
          end else if (c.armed) begin
            s.ce = c.ce - 16'h0002;
            if (c.ce == 16'h0002) begin
              s.ce = c.cr & 16'hFFFE;
              s.load_pend = 1'b0;
              s.null_cnt = 1'b0;
              s.out = ~c.out;
            end
          end
        end
        cit_pkg::mode_sw_strobe, cit_pkg::mode_hw_strobe: begin
          if (!c.out) begin
            s.out = 1'b1;
          end
          if (c.mode == cit_pkg::mode_sw_strobe ? (c.load_pend && !c.wr_hi) : trg) begin
            s.ce = c.cr;
            s.load_pend = 1'b0;
            s.null_cnt = 1'b0;
            s.armed = 1'b1;
          end else if (c.armed && (gt || c.mode == cit_pkg::mode_hw_strobe)) begin
            s.ce = c.ce - 16'h0001;
            if (c.ce == 16'h0001) begin
              s.out = 1'b0;
              s.armed = 1'b0;
            end
          end
        end
        default: begin
          s.armed = 1'b0;
        end
      endcase
    end
    cnt_step = s;
  endfunction : cnt_step

  always_comb begin
    state_next = state_reg;
    base     = {state_reg.base_hi, state_reg.base_lo[7:2], 2'b00}; // low bits ignored
    blk_hit  = (io_addr[15:2] == base[15:2]); // four bytes on an aligned base
    gate     = {state_reg.ctrl[`CIT_CTRL_GATE2_BIT], state_reg.ctrl[`CIT_CTRL_GATE1_BIT],
                state_reg.ctrl[`CIT_CTRL_GATE0_BIT]};
    outs     = {state_reg.cnt[2].out, state_reg.cnt[1].out, state_reg.cnt[0].out};
    tick[0]  = state_reg.ctrl[`CIT_CTRL_SEL0_BIT] ? int_tick : ext0_rise;
    tick[1]  = state_reg.ctrl[`CIT_CTRL_SEL1_BIT] ? int_tick : ext1_rise;
    // chained: counter 1 low half, its output edge clocks counter 2
    tick[2]  = state_reg.ctrl[`CIT_CTRL_CHAIN_BIT] ? int_tick : (outs[1] & ~state_reg.out_q[1]);
    flag_clr = 3'h0;
    for (int i = 0; i < 3; i++) begin
      req[i]      = '0;
      req[i].data = io_wdata;
    end
    // counter block, control word port at offset 3
    if (io_wr && blk_hit) begin
      if (io_addr[1:0] == `CIT_CW_PORT) begin
        if (io_wdata[7:6] == `CIT_SC_READBACK) begin
          for (int i = 0; i < 3; i++) begin
            req[i].rb_count  = io_wdata[i + 1] & ~io_wdata[`CIT_RB_NCOUNT_BIT];
            req[i].rb_status = io_wdata[i + 1] & ~io_wdata[`CIT_RB_NSTATUS_BIT];
          end
        end else begin
          req[io_wdata[7:6]].wr_ctrl = 1'b1;
        end
      end else begin
        req[io_addr[1:0]].wr_cnt = 1'b1;
      end
    end
    if (io_rd && blk_hit && io_addr[1:0] != `CIT_CW_PORT) begin
      req[io_addr[1:0]].rd = 1'b1;
    end
    // configuration registers; the counter block wins an overlap
    if (io_wr && !blk_hit) begin
      case (io_addr)
        `CIT_EVT_ENABLES_ADDR: state_next.enables = io_wdata[2:0];
        `CIT_EVT_FLAGS_ADDR:   flag_clr = io_wdata[2:0];
        `CIT_CTRL_ADDR:        state_next.ctrl = io_wdata; // reserved bits kept as written
        `CIT_BASE_HIGH_ADDR:   state_next.base_hi = io_wdata;
        `CIT_BASE_LOW_ADDR:    state_next.base_lo = io_wdata;
        default: begin
        end
      endcase
    end
    state_next.rdata_en = 1'b0;
    state_next.rdata    = 8'h00;
    if (io_rd) begin
      state_next.rdata_en = 1'b1;
      if (blk_hit) begin
        state_next.rdata = (io_addr[1:0] == `CIT_CW_PORT) ? 8'h00 : rd_byte(state_reg.cnt[io_addr[1:0]]);
      end else begin
        case (io_addr)
          `CIT_EVT_ENABLES_ADDR: state_next.rdata = {5'h00, state_reg.enables};
          `CIT_EVT_FLAGS_ADDR:   state_next.rdata = {5'h00, state_reg.flags}; // polled freely
          `CIT_CTRL_ADDR:        state_next.rdata = state_reg.ctrl;
          `CIT_BASE_HIGH_ADDR:   state_next.rdata = state_reg.base_hi;
          `CIT_BASE_LOW_ADDR:    state_next.rdata = state_reg.base_lo;
          default:               state_next.rdata_en = 1'b0;
        endcase
      end
    end
    for (int i = 0; i < 3; i++) begin
      state_next.cnt[i] = cnt_step(state_reg.cnt[i], tick[i], gate[i], req[i]);
    end
    // a rise in the clearing cycle still sets its flag
    state_next.out_q = outs;
    state_next.flags = (state_reg.flags & ~flag_clr) | (outs & ~state_reg.out_q);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg         <= '0;
      state_reg.ctrl    <= `CIT_CTRL_RST;
      state_reg.base_hi <= `CIT_BASE_HIGH_RST;
      state_reg.base_lo <= `CIT_BASE_LOW_RST;
      state_reg.enables <= `CIT_EVT_RST;
      state_reg.flags   <= `CIT_EVT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign io_rdata    = state_reg.rdata;
  assign io_rdata_en = state_reg.rdata_en;
  assign counter_out = outs;
  assign irq         = |(state_reg.flags & state_reg.enables);

endmodule : cascadable_interval_timer

`default_nettype wire

// ==== cascadable_interval_timer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module cit_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // host byte i/o
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rdata_en,
  // pins
  input wire logic        pci_clk_in,
  input wire logic        ext_clock_in_0,
  input wire logic        ext_clock_in_1,
  input wire logic [2:0]  counter_out,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [7:0] ctrl_sh;
  logic [7:0] bhi_sh;
  logic [7:0] blo_sh;
  logic [2:0] out_q;
  logic       rise_q;
  // shadows follow every host write, so readback is judged against the last write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_sh <= 8'h00;
      bhi_sh  <= 8'h01;
      blo_sh  <= 8'hDC;
      out_q   <= 3'h0;
      rise_q  <= 1'h0;
    end else begin
      if (io_wr && io_addr == 16'h01E5) ctrl_sh <= io_wdata;
      if (io_wr && io_addr == 16'h01E6) bhi_sh <= io_wdata;
      if (io_wr && io_addr == 16'h01E7) blo_sh <= io_wdata;
      out_q  <= counter_out;
      rise_q <= |(counter_out & ~out_q);
    end
  end
  a_answer_needs_read: assert property (io_rdata_en |-> $past(io_rd))
    else $error("read answer without a read");
  a_idle_data_zero: assert property (!io_rdata_en |-> io_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_control_readback: assert property (io_rd && io_addr == 16'h01E5 |=> io_rdata_en && io_rdata == ctrl_sh)
    else $error("control byte readback wrong");
  a_base_high_read: assert property (io_rd && io_addr == 16'h01E6 |=> io_rdata_en && io_rdata == bhi_sh)
    else $error("base high readback wrong");
  a_base_low_read: assert property (io_rd && io_addr == 16'h01E7 |=> io_rdata_en && io_rdata == blo_sh)
    else $error("base low readback wrong");
  a_counter_window: assert property (io_rd && io_addr[15:2] == {bhi_sh, blo_sh[7:2]} |=> io_rdata_en)
    else $error("counter window did not answer");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(io_wr) || $past(io_wr, 2) || rise_q || $past(rise_q))
    else $error("irq rose without output rise or write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(io_wr) || $past(io_wr, 2))
    else $error("irq fell without a host write");
  a_enable_off_quiet: assert property (io_wr && io_addr == 16'h01E3 && io_wdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq high with all enables off");
  c_irq_rise: cover property ($rose(irq));
  c_flag_read: cover property (io_rd && io_addr == 16'h01E4);
  c_chain_out: cover property ($rose(counter_out[2]));
endmodule : cit_checker
bind cascadable_interval_timer cit_checker chk (.clk_sys(clk_sys), .nrst(nrst), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rdata_en(io_rdata_en),
  .pci_clk_in(pci_clk_in), .ext_clock_in_0(ext_clock_in_0), .ext_clock_in_1(ext_clock_in_1),
  .counter_out(counter_out), .irq(irq));
`default_nettype wire

// ==== host_io_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
  // clock
  input  wire logic        clk_sys,
  // byte i/o requests
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata,
  output logic             io_wr,
  output logic             io_rd
);
  initial begin
    io_addr  = 16'hFFFF;
    io_wdata = 8'h00;
    io_wr    = 1'h0;
    io_rd    = 1'h0;
  end
  // one strobe cycle per byte; idle bus shows inverted values so stale data is never trusted
  task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
    logic [7:0] v;
    v = d;
    if (w && a == 16'h01E5) v[1:0] = 2'h0;
    @(negedge clk_sys);
    io_addr  = a;
    io_wdata = v;
    io_wr    = w;
    io_rd    = !w;
    @(negedge clk_sys);
    io_wr    = 1'h0;
    io_rd    = 1'h0;
    io_addr  = ~a;
    io_wdata = ~v;
  endtask : access
endmodule : host_io_model
`default_nettype wire

// ==== cascadable_interval_timer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cascadable_interval_timer_tb_top;
  logic        clk_sys = 1'h0;
  logic        nrst = 1'h0;
  logic        pci_clk_in = 1'h0;
  logic        pci_run = 1'h1;
  logic        ext_clock_in_0 = 1'h0;
  logic        ext_clock_in_1 = 1'h0;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_wr;
  logic        io_rd;
  logic        io_rdata_en;
  logic        irq;
  logic [2:0]  counter_out;
  logic [7:0]  exp_q[$];
  string       nm_q[$];
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h9A268149;

  always #5 clk_sys = ~clk_sys;
  // slower than the true pci rate: each phase must span two system clocks; toggles on falling edges
  always #20 if (pci_run) pci_clk_in = ~pci_clk_in;

  host_io_model host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));
  cascadable_interval_timer uut (.clk_sys(clk_sys), .nrst(nrst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rdata_en(io_rdata_en), .pci_clk_in(pci_clk_in),
    .ext_clock_in_0(ext_clock_in_0), .ext_clock_in_1(ext_clock_in_1), .counter_out(counter_out), .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.access(a, d, 1'h1);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    nm_q.push_back(n);
    host.access(a, 8'h00, 1'h0);
  endtask : rd

  task automatic wait_hi(input int i, input int n);
    int k;
    k = 0;
    while (counter_out[i] !== 1'h1 && k < n) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : wait_hi

  task automatic pulse(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      ext_clock_in_0 = seed[0];
      ext_clock_in_1 = 1'h1;
      repeat (4) @(negedge clk_sys);
      ext_clock_in_1 = 1'h0;
      repeat (4) @(negedge clk_sys);
    end
  endtask : pulse

  task automatic wrap_up();
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("FAIL read answers expected %0d more seen none", exp_q.size());
    end
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // answers are matched in order against the notes left by rd
  always @(negedge clk_sys) begin
    if (io_rdata_en !== 1'h0) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("FAIL read answer expected none seen %h", io_rdata);
      end else begin
        chk8(nm_q.pop_front(), exp_q.pop_front(), io_rdata);
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("FAIL run length expected 20000 seen more");
      wrap_up();
    end
  end

  initial begin
    logic [7:0] d;
    repeat (20) @(negedge clk_sys);
    nrst = 1'h1;
    @(negedge clk_sys);
    rd(16'h01E5, 8'h00, "control reset");
    rd(16'h01E6, 8'h01, "base high reset");
    rd(16'h01E7, 8'hDC, "base low reset");
    rd(16'h01E4, 8'h00, "flags reset");
    host.access(16'h01E8, 8'h00, 1'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = seed[7:0] & 8'hFC;
      wr(16'h01E5, d);
      rd(16'h01E5, d, "control readback");
    end
    // counter 0 on the internal clock, decimal bit set but counting binary
    wr(16'h01E5, 8'h34);
    wr(16'h01DF, 8'h31);
    wr(16'h01DC, 8'h10);
    wr(16'h01DC, 8'h00);
    repeat (440) @(negedge clk_sys);
    chk1("out0 before binary count", 1'h0, counter_out[0]);
    wr(16'h01DF, 8'hE2);
    rd(16'h01DC, 8'h31, "status byte");
    wait_hi(0, 400);
    chk1("out0 at terminal count", 1'h1, counter_out[0]);
    repeat (4) @(negedge clk_sys);
    chk1("irq while masked", 1'h0, irq);
    rd(16'h01E4, 8'h01, "flag after rise");
    wr(16'h01E4, 8'h00);
    rd(16'h01E4, 8'h01, "flag after write 0");
    wr(16'h01E3, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk1("irq enabled", 1'h1, irq);
    wr(16'h01E4, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk1("irq after clear", 1'h0, irq);
    rd(16'h01E4, 8'h00, "flag after clear");
    wr(16'h01E3, 8'h00);
    // chained pair: internal clock stopped, so only counter 1 can move counter 2
    pci_run = 1'h0;
    wr(16'h01E5, 8'hC0);
    wr(16'h01DF, 8'h54);
    wr(16'h01DD, 8'h02);
    wr(16'h01DF, 8'h90);
    wr(16'h01DE, 8'h02);
    pulse(4);
    chk1("chained out2 early", 1'h0, counter_out[2]);
    pulse(6);
    chk1("chained out2 done", 1'h1, counter_out[2]);
    rd(16'h01E4, 8'h06, "chained flags");
    // latch both halves: low half mid-period at 1, high half wrapped past zero
    wr(16'h01DF, 8'hDC);
    rd(16'h01DD, 8'h01, "chained low half");
    rd(16'h01DE, 8'hFF, "chained high half");
    // relocate; low base bits written nonzero are ignored by the decode
    wr(16'h01E6, 8'h03);
    wr(16'h01E7, 8'h02);
    rd(16'h01E7, 8'h02, "base low readback");
    host.access(16'h01DF, 8'h00, 1'h0);
    rd(16'h0303, 8'h00, "control word port");
    repeat (4) @(negedge clk_sys);
    wrap_up();
  end
endmodule : cascadable_interval_timer_tb_top
`default_nettype wire
